// file: inc/fan_start_map.vh
`ifndef FAN_START_MAP_VH
`define FAN_START_MAP_VH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define IDX_REMOTE1_TARGET   6'h33
`define IDX_LOCAL_TARGET     6'h34
`define IDX_REMOTE2_TARGET   6'h35
`define IDX_DYN_CONTROL_ONE  6'h36
`define IDX_DYN_STATUS       6'h38

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_TARGET_TEMP      8'h64
`define RST_DYN_CONTROL_ONE  8'h00

// ----------------------------------------
// Control register one field positions
// ----------------------------------------
`define BIT_R2_CYCLE_MSB     0
`define BIT_CORE_GUARD       1
`define BIT_R1_COPY          2
`define BIT_LOC_COPY         3
`define BIT_R2_COPY          4
`define BIT_R1_DYN_EN        5
`define BIT_LOC_DYN_EN       6
`define BIT_R2_DYN_EN        7

// ----------------------------------------
// Adjust intervals in monitoring ticks
// ----------------------------------------
`define DEC_INTERVAL_BASE    11'h004
`define INC_INTERVAL_BASE    11'h008

// ----------------------------------------
// AXI responses
// ----------------------------------------
`define RESP_OKAY            2'b00
`define RESP_SLVERR          2'b10

`endif

// file: rtl/dyn_start_unit.v
`timescale 1ns/1ps
`include "fan_start_map.vh"

module dyn_start_unit (
   input  wire       clk_sys,
   input  wire       rst_n,
   input  wire       enable,
   input  wire       tick,
   input  wire [2:0] cycle_code,
   input  wire [7:0] temp,
   input  wire [7:0] target,
   input  wire [7:0] programmed,
   output reg  [7:0] fan_start_q
);

   // ----------------------------------------
   // Interval decode
   // ----------------------------------------
   // Shift of a base; longest result is 1024 ticks
   function [10:0] interval;
      input [2:0]  code;
      input [10:0] base;
      begin
         interval = base << code;
      end
   endfunction

   wire [10:0] dec_len = interval(cycle_code, `DEC_INTERVAL_BASE);
   wire [10:0] inc_len = interval(cycle_code, `INC_INTERVAL_BASE);
   wire        hot     = $signed(temp) > $signed(target);
   wire        cool    = $signed(temp) < $signed(target);
   wire [10:0] len     = hot ? dec_len : inc_len;

   reg  [10:0] cnt_q;
   reg  [10:0] cnt_d;
   reg  [7:0]  start_d;

   // ----------------------------------------
   // Adjust loop
   // ----------------------------------------
   // Fan start moves one degree per elapsed interval
   always @* begin
      cnt_d   = cnt_q;
      start_d = fan_start_q;
      if (!enable) begin
         cnt_d   = 11'h000;
         start_d = programmed;
      end else if (!hot && !cool) begin
         cnt_d = 11'h000; // On target: hold and restart timing
      end else if (tick) begin
         if (cnt_q + 11'h001 >= len) begin
            cnt_d = 11'h000;
            // Floor and ceiling keep the signed value from wrapping
            if (hot && fan_start_q != 8'h80)
               start_d = fan_start_q - 8'h01;
            else if (cool && $signed(fan_start_q) < $signed(programmed))
               start_d = fan_start_q + 8'h01;
         end else begin
            cnt_d = cnt_q + 11'h001;
         end
      end
   end

   // Registered state
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q       <= 11'h000;
         fan_start_q <= `RST_TARGET_TEMP;
      end else begin
         cnt_q       <= cnt_d;
         fan_start_q <= start_d;
      end
   end

endmodule

// file: rtl/fan_start_ctrl.v
`timescale 1ns/1ps
`include "fan_start_map.vh"

module fan_start_ctrl (
   input  wire       clk_sys,
   input  wire       rst_n,
   // AXI4-Lite slave
   input  wire [7:0] s_axi_awaddr,
   input  wire       s_axi_awvalid,
   output reg        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0] s_axi_wstrb,
   input  wire       s_axi_wvalid,
   output reg        s_axi_wready,
   output reg  [1:0] s_axi_bresp,
   output reg        s_axi_bvalid,
   input  wire       s_axi_bready,
   input  wire [7:0] s_axi_araddr,
   input  wire       s_axi_arvalid,
   output reg        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0] s_axi_rresp,
   output reg        s_axi_rvalid,
   input  wire       s_axi_rready,
   // Measurement and system inputs
   input  wire [7:0] remote1_temp,
   input  wire [7:0] local_temp,
   input  wire [7:0] remote2_temp,
   input  wire       overtemp_pin_n,
   input  wire [7:0] core_voltage,
   input  wire [7:0] core_voltage_low_limit,
   input  wire       standby_supply,
   input  wire       config_freeze,
   input  wire       alert_enable,
   input  wire       monitor_tick,
   input  wire [2:0] remote1_cycle_code,
   input  wire [2:0] local_cycle_code,
   input  wire [1:0] remote2_cycle_low,
   input  wire [7:0] remote1_start_programmed,
   input  wire [7:0] local_start_programmed,
   input  wire [7:0] remote2_start_programmed,
   // Outputs to the fan loop and system
   output wire [7:0] remote1_fan_start_temp,
   output wire [7:0] local_fan_start_temp,
   output wire [7:0] remote2_fan_start_temp,
   output reg        core_low_status,
   output reg        alert_out,
   output reg        processor_hot_monitor_en,
   output reg        shutdown_allowed
);

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   // Host registers, then the held write request and pin history
   reg  [7:0]  remote1_target_temp_q;
   reg  [7:0]  local_target_temp_q;
   reg  [7:0]  remote2_target_temp_q;
   reg  [7:0]  dynamic_start_control_one_q;
   reg  [7:0]  aw_addr_q;
   reg  [31:0] w_data_q;
   reg  [3:0]  w_strb_q;
   reg         overtemp_q;
   reg         guard_active_q;

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   // Map a byte address to a one-hot register select
   function [4:0] decode;
      input [7:0] addr;
      begin
         decode = 5'h00;
         if (addr[1:0] == 2'b00) begin
            case (addr[7:2])
               `IDX_REMOTE1_TARGET:  decode = 5'h01;
               `IDX_LOCAL_TARGET:    decode = 5'h02;
               `IDX_REMOTE2_TARGET:  decode = 5'h04;
               `IDX_DYN_CONTROL_ONE: decode = 5'h08;
               `IDX_DYN_STATUS:      decode = 5'h10;
               default:              decode = 5'h00;
            endcase
         end
      end
   endfunction

   // Write decodes the held address, read the live one, as each is
   // stable at the edge where it is used
   wire [4:0] wr_sel = decode(aw_addr_q);
   wire [4:0] rd_sel = decode(s_axi_araddr);

   // Field views of control register one
   wire [7:0] ctl = dynamic_start_control_one_q;
   wire [2:0] remote2_adjust_cycle_code =
      {ctl[`BIT_R2_CYCLE_MSB], remote2_cycle_low};
   wire       core_voltage_guard      = ctl[`BIT_CORE_GUARD];
   wire       remote1_copy_on_overtemp = ctl[`BIT_R1_COPY];
   wire       local_copy_on_overtemp   = ctl[`BIT_LOC_COPY];
   wire       remote2_copy_on_overtemp = ctl[`BIT_R2_COPY];
   wire       remote1_dynamic_enable   = ctl[`BIT_R1_DYN_EN];
   wire       local_dynamic_enable     = ctl[`BIT_LOC_DYN_EN];
   wire       remote2_dynamic_enable   = ctl[`BIT_R2_DYN_EN];

   // ----------------------------------------
   // Write channel handshake
   // ----------------------------------------
   // Address and data may arrive in either order; held until both present
   wire aw_take  = s_axi_awvalid & s_axi_awready;
   wire w_take   = s_axi_wvalid & s_axi_wready;
   wire do_write = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
   wire host_wr  = do_write & ~config_freeze & w_strb_q[0];

   // Readies drop on take and return only after the response, so a
   // second write can never overwrite the held address or data
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
         aw_addr_q     <= 8'h00;
         w_data_q      <= 32'h0000_0000;
         w_strb_q      <= 4'h0;
      end else begin
         if (aw_take) begin
            s_axi_awready <= 1'b0;
            aw_addr_q     <= s_axi_awaddr;
         end
         if (w_take) begin
            s_axi_wready <= 1'b0;
            w_data_q     <= s_axi_wdata;
            w_strb_q     <= s_axi_wstrb;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            // Locked writes to a mapped register are dropped but still answered OKAY
            s_axi_bresp  <= (wr_sel == 5'h00) ? `RESP_SLVERR : `RESP_OKAY;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Overtemp edge detect
   // ----------------------------------------
   // Pin is synchronous; one copy per falling edge, a held level is ignored
   wire overtemp_now  = ~overtemp_pin_n;
   wire overtemp_rise = overtemp_now & ~overtemp_q;

   // Reset value matches the idle pin, so no false edge after reset
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n)
         overtemp_q <= 1'b0;
      else
         overtemp_q <= overtemp_now;
   end

   // ----------------------------------------
   // Target temperature registers
   // ----------------------------------------
   // Hardware copy wins over a host write in the same cycle
   // A locked or strobe-less write still completes on the bus
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         remote1_target_temp_q <= `RST_TARGET_TEMP;
         local_target_temp_q   <= `RST_TARGET_TEMP;
         remote2_target_temp_q <= `RST_TARGET_TEMP;
      end else begin
         if (overtemp_rise && remote1_copy_on_overtemp)
            remote1_target_temp_q <= remote1_temp;
         else if (host_wr && wr_sel[0])
            remote1_target_temp_q <= w_data_q[7:0];
         if (overtemp_rise && local_copy_on_overtemp)
            local_target_temp_q <= local_temp;
         else if (host_wr && wr_sel[1])
            local_target_temp_q <= w_data_q[7:0];
         if (overtemp_rise && remote2_copy_on_overtemp)
            remote2_target_temp_q <= remote2_temp;
         else if (host_wr && wr_sel[2])
            remote2_target_temp_q <= w_data_q[7:0];
      end
   end

   // Control register one
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n)
         dynamic_start_control_one_q <= `RST_DYN_CONTROL_ONE;
      else if (host_wr && wr_sel[3])
         dynamic_start_control_one_q <= w_data_q[7:0];
   end

   // ----------------------------------------
   // Core voltage guard
   // ----------------------------------------
   // Unsigned compare; the condition clears as soon as voltage recovers
   wire guard_now = core_voltage_guard & standby_supply &
                    (core_voltage < core_voltage_low_limit);

   // Effects are levels; the sticky status bit is kept outside
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         guard_active_q           <= 1'b0;
         core_low_status          <= 1'b0;
         alert_out                <= 1'b0;
         processor_hot_monitor_en <= 1'b1;
         shutdown_allowed         <= 1'b1;
      end else begin
         guard_active_q           <= guard_now;
         core_low_status          <= guard_now;
         alert_out                <= guard_now & alert_enable;
         processor_hot_monitor_en <= ~guard_now;
         shutdown_allowed         <= ~guard_now;
      end
   end

   // ----------------------------------------
   // Dynamic fan start units
   // ----------------------------------------
   // Per-channel slices, remote 1 in the lowest
   wire [2:0]  unit_en;
   wire [8:0]  unit_code;
   wire [23:0] unit_temp;
   wire [23:0] unit_target;
   wire [23:0] unit_prog;
   wire [23:0] unit_start;

   // Guard overrides every channel enable
   assign unit_en = {remote2_dynamic_enable, local_dynamic_enable,
                     remote1_dynamic_enable} & {3{~guard_active_q}};
   assign unit_code   = {remote2_adjust_cycle_code, local_cycle_code,
                         remote1_cycle_code};
   assign unit_temp   = {remote2_temp, local_temp, remote1_temp};
   assign unit_target = {remote2_target_temp_q, local_target_temp_q,
                         remote1_target_temp_q};
   assign unit_prog   = {remote2_start_programmed, local_start_programmed,
                         remote1_start_programmed};

   // One unit per channel; all share the monitoring tick
   genvar ch;
   generate
      for (ch = 0; ch < 3; ch = ch + 1) begin : g_unit
         dyn_start_unit u_unit (
            .clk_sys     (clk_sys),
            .rst_n       (rst_n),
            .enable      (unit_en[ch]),
            .tick        (monitor_tick),
            .cycle_code  (unit_code[3*ch+2:3*ch]),
            .temp        (unit_temp[8*ch+7:8*ch]),
            .target      (unit_target[8*ch+7:8*ch]),
            .programmed  (unit_prog[8*ch+7:8*ch]),
            .fan_start_q (unit_start[8*ch+7:8*ch])
         );
      end
   endgenerate

   // Unit outputs are flops inside the units
   assign remote1_fan_start_temp = unit_start[7:0];
   assign local_fan_start_temp   = unit_start[15:8];
   assign remote2_fan_start_temp = unit_start[23:16];

   // ----------------------------------------
   // Read channel
   // ----------------------------------------
   // Status word shows guard and live fan start values
   // Unmapped reads return zero with an error response
   reg [31:0] rd_word;

   always @* begin
      rd_word = 32'h0000_0000;
      case (rd_sel)
         5'h01:   rd_word = {24'h00_0000, remote1_target_temp_q};
         5'h02:   rd_word = {24'h00_0000, local_target_temp_q};
         5'h04:   rd_word = {24'h00_0000, remote2_target_temp_q};
         5'h08:   rd_word = {24'h00_0000, dynamic_start_control_one_q};
         5'h10:   rd_word = {7'h00, guard_active_q, unit_start};
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // One-cycle read latency; data stands until rready is seen
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= (rd_sel == 5'h00) ? `RESP_SLVERR : `RESP_OKAY;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule

// file: testbench/fan_start_asserts.sv
`timescale 1ns/1ps

// ----------------------------------------
// Bus and guard checks
// ----------------------------------------
module fan_start_asserts (
   input logic        clk_sys,
   input logic        rst_n,
   input logic        s_axi_awvalid,
   input logic        s_axi_awready,
   input logic        s_axi_wvalid,
   input logic        s_axi_wready,
   input logic [1:0]  s_axi_bresp,
   input logic        s_axi_bvalid,
   input logic        s_axi_bready,
   input logic        s_axi_arready,
   input logic        s_axi_arvalid,
   input logic [31:0] s_axi_rdata,
   input logic        s_axi_rvalid,
   input logic        s_axi_rready,
   input logic        standby_supply,
   input logic        alert_enable,
   input logic        core_low_status,
   input logic        alert_out,
   input logic        processor_hot_monitor_en,
   input logic        shutdown_allowed
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   // Write answered two edges after both halves go in together
   a_write_answer:
      assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
         && s_axi_wready |-> ##2 s_axi_bvalid) else $error("late bvalid");
   // Read answered on the next edge
   a_read_answer:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("late rvalid");
   a_resp_stands:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
         && $stable(s_axi_bresp)) else $error("bresp dropped");
   a_rdata_stands:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
         && $stable(s_axi_rdata)) else $error("rdata dropped");
   // No second write taken while the answer is pending
   a_write_blocked:
      assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write ready during answer");
   a_read_blocked:
      assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read ready during answer");
   // Only the status word uses bit 24; nothing above it
   a_upper_zero:
      assert property (s_axi_rvalid |-> s_axi_rdata[31:25] == 7'h00)
      else $error("upper read bits set");
   // Guard needs the standby supply; two edges cover the latency
   a_guard_standby:
      assert property (!standby_supply [*2] |=> !core_low_status)
      else $error("guard without standby");
   a_alert_gated:
      assert property (!alert_enable [*2] |=> !alert_out)
      else $error("alert while disabled");
   a_guard_effects:
      assert property (core_low_status |-> !processor_hot_monitor_en
         && !shutdown_allowed) else $error("guard effects missing");
endmodule

bind fan_start_ctrl fan_start_asserts fan_start_asserts_i (
   .clk_sys, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arready, .s_axi_arvalid, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_rready, .standby_supply, .alert_enable, .core_low_status,
   .alert_out, .processor_hot_monitor_en, .shutdown_allowed);

// file: testbench/monitor_tick_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// Monitoring cycle source
// ----------------------------------------
module monitor_tick_model (
   input  logic clk_sys,
   input  logic rst_n,
   input  logic run,
   output logic monitor_tick
);
   logic [2:0] cnt_q;

   // One pulse per eight clocks; silent when stopped so that the
   // bench knows exactly which pulses reached the loop
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q        <= 3'h0;
         monitor_tick <= 1'b0;
      end else begin
         cnt_q        <= run ? cnt_q + 3'h1 : 3'h0;
         monitor_tick <= run && (cnt_q == 3'h7);
      end
   end
endmodule

// file: testbench/fan_start_ctrl_tb_top.sv
`timescale 1ns/1ps
`include "fan_start_map.vh"

module fan_start_ctrl_tb_top;
   // ----------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------
   logic clk_sys = 0, rst_n = 0, tick_run = 0, late_ready = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid;
   wire s_axi_arready, s_axi_rvalid, monitor_tick;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   logic [7:0] remote1_temp = 0, local_temp = 0, remote2_temp = 0;
   logic [7:0] core_voltage = 8'h80, core_voltage_low_limit = 8'h40;
   logic overtemp_pin_n = 1, standby_supply = 0;
   logic config_freeze = 0, alert_enable = 1;
   logic [2:0] remote1_cycle_code = 0, local_cycle_code = 0;
   logic [1:0] remote2_cycle_low = 0;
   logic [7:0] remote1_start_programmed = 8'h50;
   logic [7:0] local_start_programmed = 8'h50;
   logic [7:0] remote2_start_programmed = 8'h50;
   wire [7:0] remote1_fan_start_temp, local_fan_start_temp;
   wire [7:0] remote2_fan_start_temp;
   wire core_low_status, alert_out;
   wire processor_hot_monitor_en, shutdown_allowed;
   logic [7:0] tv [0:2];
   logic [7:0] ex [0:2];
   int error_cnt = 0, tests_run = 0;

   fan_start_ctrl fan_start_ctrl_i (.clk_sys, .rst_n, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .remote1_temp, .local_temp, .remote2_temp, .overtemp_pin_n,
      .core_voltage, .core_voltage_low_limit, .standby_supply,
      .config_freeze, .alert_enable, .monitor_tick, .remote1_cycle_code,
      .local_cycle_code, .remote2_cycle_low, .remote1_start_programmed,
      .local_start_programmed, .remote2_start_programmed,
      .remote1_fan_start_temp, .local_fan_start_temp,
      .remote2_fan_start_temp, .core_low_status, .alert_out,
      .processor_hot_monitor_en, .shutdown_allowed);
   monitor_tick_model monitor_tick_model_i (.clk_sys, .rst_n,
      .run(tick_run), .monitor_tick);

   // ----------------------------------------
   // Bus and compare tasks
   // ----------------------------------------
   function automatic logic [7:0] ba(input int j);
      return {`IDX_REMOTE1_TARGET + 6'(j), 2'b00};
   endfunction

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      @(posedge clk_sys);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= !late_ready;
      do begin
         @(posedge clk_sys);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1 && !s_axi_bready) s_axi_bready <= 1'b1;
      end while (s_axi_bvalid !== 1'b1 || s_axi_bready !== 1'b1);
      s_axi_bready <= 1'b0;
      chk({30'h0, s_axi_bresp}, {30'h0, er});
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
      @(posedge clk_sys);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= !late_ready;
      do begin
         @(posedge clk_sys);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1 && !s_axi_rready) s_axi_rready <= 1'b1;
      end while (s_axi_rvalid !== 1'b1 || s_axi_rready !== 1'b1);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, ed);
      chk({30'h0, s_axi_rresp}, {30'h0, er});
   endtask

   // Counts pulses, then lets the loop settle mid-period
   task automatic tk(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         while (monitor_tick !== 1'b1) @(posedge clk_sys);
      end
      repeat (3) @(posedge clk_sys);
   endtask

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // ----------------------------------------
   // Clock, watchdog and test sequence
   // ----------------------------------------
   always #2 clk_sys = ~clk_sys;

   // Whole run is near a thousand clocks; twenty thousand is ample
   initial begin
      #80000;
      error_cnt++;
      tally_and_finish();
   end

   initial begin
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (int j = 0; j < 4; j++) rd(ba(j), j < 3 ? 32'h64 : 0,
         `RESP_OKAY);
      for (int j = 0; j < 3; j++) begin
         ex[j] = 8'h81 + 8'(j);
         wr(ba(j), {24'h0, ex[j]}, `RESP_OKAY);
         rd(ba(j), {24'h0, ex[j]}, `RESP_OKAY);
      end
      // Ready held back for one pair, so the answers must stand
      late_ready = 1'b1;
      wr(ba(3), 32'hFFFF_FF5A, `RESP_OKAY);
      rd(ba(3), 32'h5A, `RESP_OKAY);
      late_ready = 1'b0;
      wr(8'hE0, 32'h1, `RESP_OKAY);
      wr(8'hDC, 32'h1, `RESP_SLVERR);
      rd(8'hDC, 32'h0, `RESP_SLVERR);
      wr(8'hCD, 32'h1, `RESP_SLVERR);
      // Locked and strobe-less writes are answered but dropped
      config_freeze <= 1'b1;
      wr(ba(0), 32'h0, `RESP_OKAY);
      wr(ba(3), 32'h0, `RESP_OKAY);
      rd(ba(0), 32'h81, `RESP_OKAY);
      rd(ba(3), 32'h5A, `RESP_OKAY);
      config_freeze <= 1'b0;
      s_axi_wstrb   <= 4'h0;
      wr(ba(1), 32'h0, `RESP_OKAY);
      s_axi_wstrb   <= 4'hF;
      rd(ba(1), 32'h82, `RESP_OKAY);
      // One copy bit at a time; temps move while the pin stays low
      for (int i = 0; i < 3; i++) begin
         wr(ba(3), 32'h4 << i, `RESP_OKAY);
         tv[0] = 8'hF0 + 8'(i);
         tv[1] = 8'h20 + 8'(i);
         tv[2] = 8'h60 + 8'(i);
         remote1_temp   <= tv[0];
         local_temp     <= tv[1];
         remote2_temp   <= tv[2];
         repeat (2) @(posedge clk_sys);
         overtemp_pin_n <= 1'b0;
         repeat (2) @(posedge clk_sys);
         remote1_temp   <= 8'h00;
         local_temp     <= 8'h00;
         remote2_temp   <= 8'h00;
         repeat (3) @(posedge clk_sys);
         overtemp_pin_n <= 1'b1;
         ex[i] = tv[i];
         for (int j = 0; j < 3; j++) rd(ba(j), {24'h0, ex[j]},
            `RESP_OKAY);
      end
      // Hot channels: remote 1 code 0, remote 2 code 4, local off
      remote1_temp <= 8'h30;
      local_temp   <= 8'h30;
      remote2_temp <= 8'h30;
      for (int j = 0; j < 3; j++) wr(ba(j), 32'h20, `RESP_OKAY);
      wr(ba(3), 32'hA1, `RESP_OKAY);
      repeat (4) @(posedge clk_sys);
      tick_run <= 1'b1;
      tk(3);
      chk({24'h0, remote1_fan_start_temp}, 32'h50);
      tk(1);
      chk({24'h0, remote1_fan_start_temp}, 32'h4F);
      chk({24'h0, local_fan_start_temp}, 32'h50);
      tk(59);
      chk({24'h0, remote2_fan_start_temp}, 32'h50);
      tk(1);
      chk({24'h0, remote2_fan_start_temp}, 32'h4F);
      chk({24'h0, remote1_fan_start_temp}, 32'h40);
      // Guard on: hot monitor, shutdown and dynamic loop held off
      wr(ba(3), 32'hA3, `RESP_OKAY);
      standby_supply <= 1'b1;
      core_voltage   <= 8'h10;
      repeat (6) @(posedge clk_sys);
      chk({28'h0, core_low_status, alert_out, processor_hot_monitor_en,
         shutdown_allowed}, 32'hC);
      chk({24'h0, remote1_fan_start_temp}, 32'h50);
      rd(8'hE0, 32'h0150_5050, `RESP_OKAY);
      alert_enable   <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk({31'h0, alert_out}, 32'h0);
      alert_enable   <= 1'b1;
      core_voltage   <= 8'h50;
      repeat (6) @(posedge clk_sys);
      chk({28'h0, core_low_status, alert_out, processor_hot_monitor_en,
         shutdown_allowed}, 32'h3);
      // Ticks stopped on target, then cool: one step up per 16 ticks
      tick_run                 <= 1'b0;
      remote1_temp             <= 8'h20;
      remote1_cycle_code       <= 3'h1;
      remote1_start_programmed <= 8'h51;
      repeat (2) @(posedge clk_sys);
      remote1_temp <= 8'h10;
      tick_run     <= 1'b1;
      tk(15);
      chk({24'h0, remote1_fan_start_temp}, 32'h50);
      tk(1);
      chk({24'h0, remote1_fan_start_temp}, 32'h51);
      tk(16);
      chk({24'h0, remote1_fan_start_temp}, 32'h51);
      tally_and_finish();
   end
endmodule
